// ==== pkg/cofd_regs.vh ====
`ifndef COFD_REGS_VH
`define COFD_REGS_VH
// ----------------------------------------
// range class bases
// ----------------------------------------
`define COFD_BASE_XA 4'h8
`define COFD_BASE_XM 4'h0
`define COFD_BASE_YA 4'hc
`define COFD_BASE_YM 4'h4
// ----------------------------------------
// multiplier result codes
// ----------------------------------------
`define COFD_MR_FG_LAST 4'h2
`define COFD_MR_BG_FIRST 4'h4
`define COFD_MR_BG_LAST 4'h6
`define COFD_MR_BG_BIT 2
// ----------------------------------------
// multifunction operation codes
// ----------------------------------------
`define COFD_ALU_ADD 2'h0
`define COFD_ALU_SUB 2'h1
`define COFD_ALU_AVG 2'h2
`define COFD_ALU_DUAL 2'h3
`define COFD_MUL_TO_REG 2'h0
`define COFD_MUL_ACC_ADD 2'h1
`define COFD_MUL_ACC_SUB 2'h2
`define COFD_MUL_NONE 2'h3
`endif

// ==== rtl/cofd_decoder.v ====
`include "cofd_regs.vh"

module cofd_decoder (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // decode request
  input wire dec_valid,
  input wire is_float,
  input wire is_wide,
  input wire [1:0] mul_op,
  input wire [1:0] alu_op,
  input wire [1:0] mul_x_code,
  input wire [1:0] mul_y_code,
  input wire [1:0] alu_x_code,
  input wire [1:0] alu_y_code,
  input wire [3:0] mul_dst_code,
  input wire [3:0] alu_dst_code,
  input wire [3:0] alu_dst2_code,
  input wire [3:0] pair_select_4bit,
  input wire [2:0] pair_select_3bit,
  input wire pair_x_range_a,
  input wire pair_x_range_m,
  input wire pair_y_range_a,
  input wire pair_y_range_m,
  input wire [3:0] mult_result_select,
  input wire mr_in_multifunction,
  input wire [2:0] index_select_gen1,
  input wire [2:0] index_select_gen2,
  input wire [2:0] modifier_select_gen1,
  input wire [2:0] modifier_select_gen2,
  input wire [2:0] base_select_gen1,
  input wire [2:0] base_select_gen2,
  // decoded operands, one cycle after the request
  output reg out_valid_r,
  output reg illegal_r,
  output reg mul_en_r,
  output reg alu_en_r,
  output reg [3:0] mul_x_reg_r,
  output reg [3:0] mul_y_reg_r,
  output reg [3:0] alu_x_reg_r,
  output reg [3:0] alu_y_reg_r,
  output reg [3:0] mul_dst_reg_r,
  output reg [3:0] sum_dst_reg_r,
  output reg [3:0] diff_dst_reg_r,
  output reg sum_en_r,
  output reg diff_en_r,
  output reg alu_halve_r,
  output reg acc_en_r,
  output reg acc_subtract_r,
  output reg round_en_r,
  output reg float_r,
  output reg [3:0] pair4_even_r,
  output reg [3:0] pair3_even_r,
  output reg [3:0] pair_xa_even_r,
  output reg [3:0] pair_xm_even_r,
  output reg [3:0] pair_ya_even_r,
  output reg [3:0] pair_ym_even_r,
  output reg [1:0] mr_portion_r,
  output reg mr_background_r,
  output reg [3:0] index_reg_gen1_r,
  output reg [3:0] index_reg_gen2_r,
  output reg [3:0] modifier_reg_gen1_r,
  output reg [3:0] modifier_reg_gen2_r,
  output reg [3:0] base_reg_gen1_r,
  output reg [3:0] base_reg_gen2_r
);

// ----------------------------------------
// decode helpers
// ----------------------------------------
// range classes: code plus a fixed base, same for fixed and float views
function [3:0] cofd_range;
  input [1:0] code;
  input [3:0] base;
  begin
    cofd_range = base | {2'h0, code};
  end
endfunction

// pair from 1-bit class: even register of selected pair
function [3:0] cofd_pair1;
  input sel;
  input [3:0] base;
  begin
    cofd_pair1 = base | {2'h0, sel, 1'b0};
  end
endfunction

// generator two registers sit eight above generator one
function [3:0] cofd_gen;
  input [2:0] code;
  input second;
  begin
    cofd_gen = {second, code};
  end
endfunction

// ----------------------------------------
// combinational decode
// ----------------------------------------
wire mr_bad;
wire pair_bad;
wire op_bad;
wire dual;
wire to_acc;
wire mul_on;
wire refuse;

assign dual = (alu_op == `COFD_ALU_DUAL);
assign mul_on = (mul_op != `COFD_MUL_NONE);
assign to_acc = (mul_op == `COFD_MUL_ACC_ADD) || (mul_op == `COFD_MUL_ACC_SUB);
// background portions may not appear in any multifunction form
assign mr_bad = (mult_result_select > `COFD_MR_BG_LAST) ||
  ((mult_result_select > `COFD_MR_FG_LAST) && (mult_result_select < `COFD_MR_BG_FIRST)) ||
  (mr_in_multifunction && mult_result_select[`COFD_MR_BG_BIT]);
// in wide float, an odd 4-bit pair code has no register pair
assign pair_bad = is_float && is_wide && pair_select_4bit[0];
// float has no accumulator forms; only mul_op is checked against is_float
assign op_bad = is_float && to_acc;
// one refusal term, so the flag and the mul and alu enables can never disagree
assign refuse = mr_bad || pair_bad || op_bad;

// ----------------------------------------
// next-value decode
// ----------------------------------------
// unit enables and flags
reg out_valid_nxt;
reg illegal_nxt;
reg mul_en_nxt;
reg alu_en_nxt;
reg sum_en_nxt;
reg diff_en_nxt;
reg alu_halve_nxt;
reg acc_en_nxt;
reg acc_subtract_nxt;
reg round_en_nxt;
reg float_nxt;
// operand and destination registers
reg [3:0] mul_x_reg_nxt;
reg [3:0] mul_y_reg_nxt;
reg [3:0] alu_x_reg_nxt;
reg [3:0] alu_y_reg_nxt;
reg [3:0] mul_dst_reg_nxt;
reg [3:0] sum_dst_reg_nxt;
reg [3:0] diff_dst_reg_nxt;
// pair, result and address-generator selects
reg [3:0] pair4_even_nxt;
reg [3:0] pair3_even_nxt;
reg [3:0] pair_xa_even_nxt;
reg [3:0] pair_xm_even_nxt;
reg [3:0] pair_ya_even_nxt;
reg [3:0] pair_ym_even_nxt;
reg [1:0] mr_portion_nxt;
reg mr_background_nxt;
reg [3:0] index_reg_gen1_nxt;
reg [3:0] index_reg_gen2_nxt;
reg [3:0] modifier_reg_gen1_nxt;
reg [3:0] modifier_reg_gen2_nxt;
reg [3:0] base_reg_gen1_nxt;
reg [3:0] base_reg_gen2_nxt;

// the whole decode is combinational; the flops below only delay it one cycle
always @*
begin
  out_valid_nxt = dec_valid;
  illegal_nxt = dec_valid && refuse;
  // an illegal encoding never sets mul_en_nxt or alu_en_nxt; the other enables are not gated
  mul_en_nxt = dec_valid && !refuse && mul_on && !dual;
  alu_en_nxt = dec_valid && !refuse;
  mul_x_reg_nxt = cofd_range(mul_x_code, `COFD_BASE_XM);
  mul_y_reg_nxt = cofd_range(mul_y_code, `COFD_BASE_YM);
  // dual form takes any two registers; otherwise restricted ranges
  alu_x_reg_nxt = dual ? mul_dst_code : cofd_range(alu_x_code, `COFD_BASE_XA);
  alu_y_reg_nxt = dual ? alu_dst2_code : cofd_range(alu_y_code, `COFD_BASE_YA);
  mul_dst_reg_nxt = mul_dst_code;
  sum_dst_reg_nxt = alu_dst_code;
  diff_dst_reg_nxt = dual ? alu_dst2_code : alu_dst_code;
  sum_en_nxt = (alu_op != `COFD_ALU_SUB);
  diff_en_nxt = (alu_op == `COFD_ALU_SUB) || dual;
  alu_halve_nxt = (alu_op == `COFD_ALU_AVG);
  acc_en_nxt = mul_on && to_acc;
  acc_subtract_nxt = (mul_op == `COFD_MUL_ACC_SUB);
  // rounding applies only when the product lands in a data register
  round_en_nxt = mul_on && !to_acc && !is_float;
  float_nxt = is_float;
  pair4_even_nxt = {pair_select_4bit[3:1], 1'b0};
  pair3_even_nxt = {pair_select_3bit, 1'b0};
  pair_xa_even_nxt = cofd_pair1(pair_x_range_a, `COFD_BASE_XA);
  pair_xm_even_nxt = cofd_pair1(pair_x_range_m, `COFD_BASE_XM);
  pair_ya_even_nxt = cofd_pair1(pair_y_range_a, `COFD_BASE_YA);
  pair_ym_even_nxt = cofd_pair1(pair_y_range_m, `COFD_BASE_YM);
  mr_portion_nxt = mult_result_select[1:0];
  mr_background_nxt = mult_result_select[`COFD_MR_BG_BIT];
  index_reg_gen1_nxt = cofd_gen(index_select_gen1, 1'b0);
  index_reg_gen2_nxt = cofd_gen(index_select_gen2, 1'b1);
  modifier_reg_gen1_nxt = cofd_gen(modifier_select_gen1, 1'b0);
  modifier_reg_gen2_nxt = cofd_gen(modifier_select_gen2, 1'b1);
  base_reg_gen1_nxt = cofd_gen(base_select_gen1, 1'b0);
  base_reg_gen2_nxt = cofd_gen(base_select_gen2, 1'b1);
end

// ----------------------------------------
// result registers
// ----------------------------------------
// outputs refresh every cycle; out_valid_r marks which cycles carry a request
always @(posedge sys_clk or negedge resetn)
begin
  if (!resetn)
  begin
    out_valid_r <= 1'b0;
    illegal_r <= 1'b0;
    mul_en_r <= 1'b0;
    alu_en_r <= 1'b0;
    mul_x_reg_r <= 4'h0;
    mul_y_reg_r <= 4'h0;
    alu_x_reg_r <= 4'h0;
    alu_y_reg_r <= 4'h0;
    mul_dst_reg_r <= 4'h0;
    sum_dst_reg_r <= 4'h0;
    diff_dst_reg_r <= 4'h0;
    sum_en_r <= 1'b0;
    diff_en_r <= 1'b0;
    alu_halve_r <= 1'b0;
    acc_en_r <= 1'b0;
    acc_subtract_r <= 1'b0;
    round_en_r <= 1'b0;
    float_r <= 1'b0;
    pair4_even_r <= 4'h0;
    pair3_even_r <= 4'h0;
    pair_xa_even_r <= 4'h0;
    pair_xm_even_r <= 4'h0;
    pair_ya_even_r <= 4'h0;
    pair_ym_even_r <= 4'h0;
    mr_portion_r <= 2'h0;
    mr_background_r <= 1'b0;
    index_reg_gen1_r <= 4'h0;
    index_reg_gen2_r <= 4'h0;
    modifier_reg_gen1_r <= 4'h0;
    modifier_reg_gen2_r <= 4'h0;
    base_reg_gen1_r <= 4'h0;
    base_reg_gen2_r <= 4'h0;
  end
  else
  begin
    // flops only; every decode term lives in the block above
    out_valid_r <= out_valid_nxt;
    illegal_r <= illegal_nxt;
    mul_en_r <= mul_en_nxt;
    alu_en_r <= alu_en_nxt;
    mul_x_reg_r <= mul_x_reg_nxt;
    mul_y_reg_r <= mul_y_reg_nxt;
    alu_x_reg_r <= alu_x_reg_nxt;
    alu_y_reg_r <= alu_y_reg_nxt;
    mul_dst_reg_r <= mul_dst_reg_nxt;
    sum_dst_reg_r <= sum_dst_reg_nxt;
    diff_dst_reg_r <= diff_dst_reg_nxt;
    sum_en_r <= sum_en_nxt;
    diff_en_r <= diff_en_nxt;
    alu_halve_r <= alu_halve_nxt;
    acc_en_r <= acc_en_nxt;
    acc_subtract_r <= acc_subtract_nxt;
    round_en_r <= round_en_nxt;
    float_r <= float_nxt;
    pair4_even_r <= pair4_even_nxt;
    pair3_even_r <= pair3_even_nxt;
    pair_xa_even_r <= pair_xa_even_nxt;
    pair_xm_even_r <= pair_xm_even_nxt;
    pair_ya_even_r <= pair_ya_even_nxt;
    pair_ym_even_r <= pair_ym_even_nxt;
    mr_portion_r <= mr_portion_nxt;
    mr_background_r <= mr_background_nxt;
    index_reg_gen1_r <= index_reg_gen1_nxt;
    index_reg_gen2_r <= index_reg_gen2_nxt;
    modifier_reg_gen1_r <= modifier_reg_gen1_nxt;
    modifier_reg_gen2_r <= modifier_reg_gen2_nxt;
    base_reg_gen1_r <= base_reg_gen1_nxt;
    base_reg_gen2_r <= base_reg_gen2_nxt;
  end
end

endmodule // cofd_decoder

// ==== bench/cofd_chk.sv ====
module cofd_chk (
  // request side
  input wire sys_clk,
  input wire resetn,
  input wire dec_valid,
  input wire [1:0] alu_op,
  input wire [1:0] mul_x_code,
  input wire [3:0] mult_result_select,
  input wire mr_in_multifunction,
  input wire [2:0] index_select_gen2,
  // decoded side
  input wire out_valid_r,
  input wire illegal_r,
  input wire mul_en_r,
  input wire alu_en_r,
  input wire sum_en_r,
  input wire diff_en_r,
  input wire alu_halve_r,
  input wire mr_background_r,
  input wire [3:0] index_reg_gen2_r,
  input wire [3:0] mul_x_reg_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  AST_VALID: assert property (dec_valid |=> out_valid_r)
    else $error("no decode one cycle after request");
  AST_MR_BG: assert property (dec_valid && mr_in_multifunction && mult_result_select[2]
    |=> illegal_r && !mul_en_r && !alu_en_r) else $error("background acc accepted");
  AST_MR_GAP: assert property (dec_valid && (mult_result_select == 4'h3
    || mult_result_select > 4'h6) |=> illegal_r) else $error("gap code accepted");
  AST_MR_BIT: assert property (dec_valid
    |=> mr_background_r == $past(mult_result_select[2])) else $error("result half wrong");
  AST_RANGE: assert property (dec_valid
    |=> mul_x_reg_r == {2'h0, $past(mul_x_code)}) else $error("mul x out of range");
  AST_DUAL: assert property (dec_valid && alu_op == 2'h3 ##1 !illegal_r
    |-> sum_en_r && diff_en_r && !mul_en_r) else $error("dual form wrong");
  AST_AVG: assert property (dec_valid && alu_op == 2'h2 ##1 !illegal_r
    |-> alu_halve_r && alu_en_r) else $error("average not halved");
  AST_GEN2: assert property (dec_valid
    |=> index_reg_gen2_r == {1'b1, $past(index_select_gen2)}) else $error("gen two index wrong");
endmodule // cofd_chk

// ==== bench/cofd_rf_model.sv ====
// register file read port; one location per code, no fixed/float split
module cofd_rf_model (
  // read port
  input wire [3:0] rd_idx,
  output logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  assign rd_data = {~rd_idx, rd_idx};
endmodule // cofd_rf_model

// ==== bench/cofd_tb_top.sv ====
module cofd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, resetn = 0, dec_valid = 0, is_float = 0, is_wide = 0;
  logic pair_x_range_a = 0, pair_x_range_m = 0, pair_y_range_a = 0, pair_y_range_m = 0;
  logic mr_in_multifunction = 0;
  logic [1:0] mul_op = '0, alu_op = '0, mul_x_code = '0, mul_y_code = '0;
  logic [1:0] alu_x_code = '0, alu_y_code = '0;
  logic [3:0] mul_dst_code = '0, alu_dst_code = '0, alu_dst2_code = '0;
  logic [3:0] pair_select_4bit = '0, mult_result_select = '0;
  logic [2:0] pair_select_3bit = '0, index_select_gen1 = '0, index_select_gen2 = '0;
  logic [2:0] modifier_select_gen1 = '0, modifier_select_gen2 = '0;
  logic [2:0] base_select_gen1 = '0, base_select_gen2 = '0;
  logic out_valid_r, illegal_r, mul_en_r, alu_en_r, sum_en_r, diff_en_r, alu_halve_r;
  logic acc_en_r, acc_subtract_r, round_en_r, float_r, mr_background_r;
  logic [1:0] mr_portion_r;
  logic [3:0] mul_x_reg_r, mul_y_reg_r, alu_x_reg_r, alu_y_reg_r, mul_dst_reg_r;
  logic [3:0] sum_dst_reg_r, diff_dst_reg_r, pair4_even_r, pair3_even_r;
  logic [3:0] pair_xa_even_r, pair_xm_even_r, pair_ya_even_r, pair_ym_even_r;
  logic [3:0] index_reg_gen1_r, index_reg_gen2_r, modifier_reg_gen1_r;
  logic [3:0] modifier_reg_gen2_r, base_reg_gen1_r, base_reg_gen2_r;
  logic [7:0] rd_data;
  logic ill;
  logic [63:0] rnd;
  integer seed = 32'h1293937f;
  int err_total = 0, comparisons = 0;
  cofd_decoder dut (.*);
  cofd_rf_model u_rf (.rd_idx(alu_x_reg_r), .rd_data(rd_data));
  initial forever #4 sys_clk = ~sys_clk;
  task ck(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task stop_test();
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // checks last cycle's request, then launches the next one back to back
  task run(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      #1;
      ill = mult_result_select == 4'h3 || mult_result_select > 4'h6
        || (mult_result_select[2] && mr_in_multifunction) || (is_float && is_wide
        && pair_select_4bit[0]) || (is_float && (mul_op == 2'h1 || mul_op == 2'h2));
      ck(out_valid_r, dec_valid);
      if (dec_valid)
      begin
        ck(illegal_r, ill);
        ck(alu_en_r, !ill);
        ck(mul_en_r, !ill && mul_op != 2'h3 && alu_op != 2'h3);
        ck(pair4_even_r, {pair_select_4bit[3:1], 1'b0});
        ck(pair3_even_r, {pair_select_3bit, 1'b0});
        ck(pair_xa_even_r, {2'h2, pair_x_range_a, 1'b0});
        ck(pair_xm_even_r, {2'h0, pair_x_range_m, 1'b0});
        ck(pair_ya_even_r, {2'h3, pair_y_range_a, 1'b0});
        ck(pair_ym_even_r, {2'h1, pair_y_range_m, 1'b0});
        ck(mr_portion_r, mult_result_select[1:0]);
        ck(mr_background_r, mult_result_select[2]);
        ck(mul_x_reg_r, {2'h0, mul_x_code});
        ck(index_reg_gen1_r, {1'b0, index_select_gen1});
        ck(index_reg_gen2_r, {1'b1, index_select_gen2});
        ck(modifier_reg_gen1_r, {1'b0, modifier_select_gen1});
        ck(modifier_reg_gen2_r, {1'b1, modifier_select_gen2});
        ck(base_reg_gen1_r, {1'b0, base_select_gen1});
        ck(base_reg_gen2_r, {1'b1, base_select_gen2});
      end
      if (dec_valid && !ill)
      begin
        ck(alu_halve_r, alu_op == 2'h2);
        ck(sum_en_r, alu_op != 2'h1);
        ck(diff_en_r, alu_op == 2'h1 || alu_op == 2'h3);
        ck(acc_en_r, mul_op == 2'h1 || mul_op == 2'h2);
        ck(float_r, is_float);
        if (alu_op == 2'h3)
        begin
          ck(sum_dst_reg_r, alu_dst_code);
          ck(diff_dst_reg_r, alu_dst2_code);
          ck(alu_x_reg_r, mul_dst_code);
          ck(alu_y_reg_r, alu_dst2_code);
        end
        else
        begin
          ck(sum_dst_reg_r, alu_dst_code);
          ck(diff_dst_reg_r, alu_dst_code);
          ck(alu_x_reg_r, {2'h2, alu_x_code});
          ck(rd_data, {~{2'h2, alu_x_code}, 2'h2, alu_x_code});
          ck(alu_y_reg_r, {2'h3, alu_y_code});
        end
        if (mul_op != 2'h3 && alu_op != 2'h3)
        begin
          ck(mul_y_reg_r, {2'h1, mul_y_code});
          ck(mul_dst_reg_r, mul_dst_code);
          ck(acc_subtract_r, mul_op == 2'h2);
          if (!is_float)
            ck(round_en_r, mul_op == 2'h0);
          else
            ck(round_en_r, 1'b0);
        end
      end
      rnd = {$random(seed), $random(seed)};
      {dec_valid, is_float, is_wide, mul_op, alu_op, mul_x_code, mul_y_code, alu_x_code,
        alu_y_code, mul_dst_code, alu_dst_code, alu_dst2_code, pair_select_4bit,
        pair_select_3bit, pair_x_range_a, pair_x_range_m, pair_y_range_a, pair_y_range_m,
        mult_result_select, mr_in_multifunction, index_select_gen1, index_select_gen2,
        modifier_select_gen1, modifier_select_gen2, base_select_gen1,
        base_select_gen2} = rnd[60:0];
    end
  endtask
  initial
  begin
    repeat (10) @(posedge sys_clk);
    #1 resetn = 1;
    run(600);
    resetn = 0;
    #1 ck(out_valid_r, 1'b0);
    ck(illegal_r, 1'b0);
    ck(mul_en_r, 1'b0);
    repeat (2) @(posedge sys_clk);
    #1 resetn = 1;
    run(600);
    stop_test();
  end
  initial
  begin
    #100us;
    err_total++;
    stop_test();
  end
endmodule // cofd_tb_top
bind cofd_decoder cofd_chk u_chk (.*);
